// file: logic/fcs_engine.sv
// Byte-wide Ethernet frame check sequence accumulator.
`timescale 1ns/100ps
module fcs_engine (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   // Byte feed.
   input wire logic init,
   input wire logic en,
   input wire logic [7:0] data,
   // Running remainder, reflected form.
   output logic [31:0] crc
);

   // One byte of the reflected polynomial division, bit by bit.
   function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
      logic [31:0] r;
      r = c;
      for (int i = 0; i < 8; i++) begin
         if (r[0] ^ d[i]) begin
            r = (r >> 1) ^ 32'hEDB88320;
         end else begin
            r = r >> 1;
         end
      end
      return r;
   endfunction : crc_byte

   // Init wins over a byte so a new frame never inherits the old remainder.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         crc <= 32'hFFFFFFFF;
      end else if (init) begin
         crc <= 32'hFFFFFFFF;
      end else if (en) begin
         crc <= crc_byte(crc, data);
      end
   end

endmodule : fcs_engine

// file: logic/mgmt_hdr_pkg.sv
// Constants, register map and state codes shared by the management port header framer.
package mgmt_hdr_pkg;

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   // Register byte offsets and control fields.
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_IHDR = 8'h08;
   localparam logic [7:0] ADDR_COUNT = 8'h0C;
   localparam int CTRL_FWD_BIT = 0;
   localparam int CTRL_DUAL_BIT = 1;
   localparam int CTRL_SPEED_LSB = 2;
   localparam int STAT_DUPLEX_BIT = 0;
   localparam int STAT_PAUSED_BIT = 1;
   localparam int STAT_SPEED_LSB = 2;
   localparam int STAT_BADPOL_BIT = 4;
   localparam logic [1:0] SPEED_10 = 2'h0;
   localparam logic [1:0] SPEED_100 = 2'h1;
   localparam logic [1:0] SPEED_1000 = 2'h2;
   localparam logic CTRL_FWD_RESET = 1'h1;
   localparam logic CTRL_DUAL_RESET = 1'h0;
   localparam logic [1:0] CTRL_SPEED_RESET = SPEED_1000;

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   // Header layout.
   localparam logic [2:0] OPC_PLAIN = 3'h0;
   localparam logic [2:0] OPC_STAMP = 3'h1;
   localparam int MAC_ADDR_BYTES = 12;
   localparam int HDR_SHORT_BYTES = 4;
   localparam int HDR_LONG_BYTES = 8;
   localparam int EG_OPC_LSB = 29;
   localparam int EG_CLASS_LSB = 16;
   localparam int EG_CAUSE_LSB = 8;
   localparam int EG_TC_LSB = 5;
   localparam int EG_DIR_BIT = 37;
   localparam int EG_SPORT_LSB = 32;
   localparam int IN_TC_LSB = 26;
   localparam int IN_POL_LSB = 24;
   localparam int IN_TREQ_BIT = 23;
   localparam logic [7:0] NO_CLASS = 8'h00;
   localparam logic [1:0] POL_RESERVED = 2'h3;
   localparam logic [22:0] PORT_MASK_VALID = 23'h00013F;
   localparam logic [7:0] PAUSE_TYPE_HI = 8'h88;
   localparam int PAUSE_QUANTA_HI = 16;

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   // Pause slot of 512 bit times, in cycles of the 10 ns clock (rounded up).
   localparam int CLK_NS = 10;
   localparam int SLOT_NS_1000 = 512;
   localparam int SLOT_NS_100 = 5120;
   localparam int SLOT_NS_10 = 51200;
   localparam int SLOT_CYC_1000 = (SLOT_NS_1000 + CLK_NS - 1) / CLK_NS;
   localparam int SLOT_CYC_100 = (SLOT_NS_100 + CLK_NS - 1) / CLK_NS;
   localparam int SLOT_CYC_10 = (SLOT_NS_10 + CLK_NS - 1) / CLK_NS;

   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_ADDR = 6'h02,
      ST_HDR = 6'h04,
      ST_BODY = 6'h08,
      ST_FCS = 6'h10,
      ST_DROP = 6'h20
   } eg_state_t;

endpackage : mgmt_hdr_pkg

// file: logic/mgmt_port_header_framer.sv
// Management port framer: header insertion toward the CPU, header parsing from the host, APB registers.
//
// The APB slave port and the placing of the registers were decided locally.
`timescale 1ns/100ps
module mgmt_port_header_framer #(
   parameter int SLOT_CYC_10 = mgmt_hdr_pkg::SLOT_CYC_10
) (
   // Clock and reset.
   input wire logic MCLK,
   input wire logic SYS_RST,
   // APB register port.
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // Frames from the switch toward the CPU, with sideband valid on the first byte.
   input wire logic E_IN_VALID,
   input wire logic [7:0] E_IN_DATA,
   input wire logic E_IN_LAST,
   output logic E_IN_READY,
   input wire logic E_IN_PAUSE,
   input wire logic E_IN_WAN,
   input wire logic E_IN_STAMP,
   input wire logic [7:0] E_IN_CLASS,
   input wire logic [5:0] E_IN_CAUSE,
   input wire logic [2:0] E_IN_TC,
   input wire logic [4:0] E_IN_PORT,
   input wire logic E_IN_DIR,
   input wire logic [31:0] E_IN_TIME,
   // Framed bytes toward the management MAC.
   output logic E_OUT_VALID,
   output logic [7:0] E_OUT_DATA,
   output logic E_OUT_LAST,
   output logic E_OUT_SEL,
   // Frames from the host (without FCS stripping).
   input wire logic I_IN_VALID,
   input wire logic [7:0] I_IN_DATA,
   input wire logic I_IN_LAST,
   // Host frames toward the switch with the header removed.
   output logic I_OUT_VALID,
   output logic [7:0] I_OUT_DATA,
   output logic I_OUT_LAST,
   // Decoded host header.
   output logic I_HDR_VALID,
   output logic I_LOOKUP,
   output logic [2:0] I_TC,
   output logic [1:0] I_TAG_POLICY,
   output logic I_TIME_REQ,
   output logic [22:0] I_PORT_MASK
);

   logic fwd_en;
   logic dual_en;
   logic [1:0] speed;
   logic bad_policy;
   logic [31:0] last_ihdr;
   logic [15:0] hdr_count;
   mgmt_hdr_pkg::eg_state_t state;
   mgmt_hdr_pkg::eg_state_t next_state;
   logic take;
   logic [3:0] cnt;
   logic [2:0] hcnt;
   logic long_hdr;
   logic [63:0] hdr;
   logic emit_valid;
   logic [7:0] emit_data;
   logic [31:0] crc;
   logic [5:0] icnt;
   logic ipause;
   logic [31:0] ihdr;
   logic [15:0] quanta;
   logic pause_active;
   logic [15:0] pause_left;
   logic [12:0] slot_cnt;

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   // APB slave: one wait state, so PREADY and PRDATA both come from flops.
   always_ff @(posedge MCLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         PREADY <= 1'b0;
         PSLVERR <= 1'b0;
         PRDATA <= 32'h00000000;
      end else begin
         PREADY <= PSEL && PENABLE && !PREADY;
         PSLVERR <= PSEL && PENABLE && !PREADY && !(PADDR inside {mgmt_hdr_pkg::ADDR_CTRL,
            mgmt_hdr_pkg::ADDR_STATUS, mgmt_hdr_pkg::ADDR_IHDR, mgmt_hdr_pkg::ADDR_COUNT});
         PRDATA <= 32'h00000000;
         if (PSEL && PENABLE && !PREADY && !PWRITE) begin
            case (PADDR)
               mgmt_hdr_pkg::ADDR_CTRL: PRDATA <= {28'h0, speed, dual_en, fwd_en};
               mgmt_hdr_pkg::ADDR_STATUS: PRDATA <= {27'h0, bad_policy, speed, pause_active, 1'b1};
               mgmt_hdr_pkg::ADDR_IHDR: PRDATA <= last_ihdr;
               mgmt_hdr_pkg::ADDR_COUNT: PRDATA <= {16'h0, hdr_count};
               default: PRDATA <= 32'h00000000;
            endcase
         end
      end
   end

   // Control writes take effect on the completing edge; a reserved speed code is ignored.
   always_ff @(posedge MCLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         fwd_en <= mgmt_hdr_pkg::CTRL_FWD_RESET;
         dual_en <= mgmt_hdr_pkg::CTRL_DUAL_RESET;
         speed <= mgmt_hdr_pkg::CTRL_SPEED_RESET;
      end else if (PSEL && PENABLE && PREADY && PWRITE && PADDR == mgmt_hdr_pkg::ADDR_CTRL) begin
         fwd_en <= PWDATA[mgmt_hdr_pkg::CTRL_FWD_BIT];
         dual_en <= PWDATA[mgmt_hdr_pkg::CTRL_DUAL_BIT];
         if (PWDATA[mgmt_hdr_pkg::CTRL_SPEED_LSB +: 2] != 2'h3) begin
            speed <= PWDATA[mgmt_hdr_pkg::CTRL_SPEED_LSB +: 2];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   // Egress sequencing: address bytes, inserted header, body, regenerated FCS.
   assign take = E_IN_VALID && E_IN_READY;

   always_comb begin
      next_state = state;
      case (state)
         mgmt_hdr_pkg::ST_IDLE: begin
            if (take) begin
               if (!fwd_en && !E_IN_CAUSE[0] && !E_IN_STAMP && !E_IN_PAUSE) begin
                  next_state = E_IN_LAST ? mgmt_hdr_pkg::ST_IDLE : mgmt_hdr_pkg::ST_DROP;
               end else if (E_IN_PAUSE) begin
                  next_state = E_IN_LAST ? mgmt_hdr_pkg::ST_FCS : mgmt_hdr_pkg::ST_BODY;
               end else begin
                  next_state = E_IN_LAST ? mgmt_hdr_pkg::ST_FCS : mgmt_hdr_pkg::ST_ADDR;
               end
            end
         end
         mgmt_hdr_pkg::ST_ADDR: begin
            if (take && E_IN_LAST) begin
               next_state = mgmt_hdr_pkg::ST_FCS;
            end else if (take && cnt == 4'(mgmt_hdr_pkg::MAC_ADDR_BYTES - 1)) begin
               next_state = mgmt_hdr_pkg::ST_HDR;
            end
         end
         mgmt_hdr_pkg::ST_HDR: begin
            if (hcnt == (long_hdr ? 3'(mgmt_hdr_pkg::HDR_LONG_BYTES - 1) : 3'(mgmt_hdr_pkg::HDR_SHORT_BYTES - 1))) begin
               next_state = mgmt_hdr_pkg::ST_BODY;
            end
         end
         mgmt_hdr_pkg::ST_BODY: begin
            if (take && E_IN_LAST) begin
               next_state = mgmt_hdr_pkg::ST_FCS;
            end
         end
         mgmt_hdr_pkg::ST_FCS: begin
            if (hcnt == 3'h3) begin
               next_state = mgmt_hdr_pkg::ST_IDLE;
            end
         end
         mgmt_hdr_pkg::ST_DROP: begin
            if (take && E_IN_LAST) begin
               next_state = mgmt_hdr_pkg::ST_IDLE;
            end
         end
         default: next_state = mgmt_hdr_pkg::ST_IDLE;
      endcase
   end

   // Ready depends only on the coming state and the pause flag, so it can be a flop; a pause holds off new frames only.
   always_ff @(posedge MCLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         state <= mgmt_hdr_pkg::ST_IDLE;
         E_IN_READY <= 1'b0;
      end else begin
         state <= next_state;
         E_IN_READY <= (next_state == mgmt_hdr_pkg::ST_IDLE && !pause_active) ||
            next_state inside {mgmt_hdr_pkg::ST_ADDR, mgmt_hdr_pkg::ST_BODY, mgmt_hdr_pkg::ST_DROP};
      end
   end

   // Byte counters: cnt walks the address bytes, hcnt the header and FCS bytes.
   always_ff @(posedge MCLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         cnt <= 4'h0;
         hcnt <= 3'h0;
      end else begin
         if (state == mgmt_hdr_pkg::ST_IDLE) begin
            cnt <= 4'h1;
         end else if (take && state == mgmt_hdr_pkg::ST_ADDR) begin
            cnt <= cnt + 4'h1;
         end
         if (state != next_state) begin
            hcnt <= 3'h0;
         end else if (state inside {mgmt_hdr_pkg::ST_HDR, mgmt_hdr_pkg::ST_FCS}) begin
            hcnt <= hcnt + 3'h1;
         end
      end
   end

   // Header image, captured with the first byte; a short header sits in the upper word.
   always_ff @(posedge MCLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         hdr <= 64'h0;
         long_hdr <= 1'b0;
         E_OUT_SEL <= 1'b0;
      end else if (take && state == mgmt_hdr_pkg::ST_IDLE) begin
         long_hdr <= E_IN_STAMP;
         E_OUT_SEL <= dual_en && E_IN_WAN;
         if (E_IN_STAMP) begin
            hdr <= 64'h0;
            hdr[mgmt_hdr_pkg::EG_OPC_LSB + 32 +: 3] <= mgmt_hdr_pkg::OPC_STAMP;
            hdr[mgmt_hdr_pkg::EG_DIR_BIT] <= E_IN_DIR;
            hdr[mgmt_hdr_pkg::EG_SPORT_LSB +: 5] <= E_IN_PORT;
            hdr[31:0] <= E_IN_TIME;
         end else begin
            hdr <= 64'h0;
            hdr[mgmt_hdr_pkg::EG_OPC_LSB + 32 +: 3] <= mgmt_hdr_pkg::OPC_PLAIN;
            hdr[mgmt_hdr_pkg::EG_CLASS_LSB + 32 +: 8] <= E_IN_CLASS;
            hdr[mgmt_hdr_pkg::EG_CAUSE_LSB + 32 +: 8] <= {2'h0, E_IN_CAUSE};
            hdr[mgmt_hdr_pkg::EG_TC_LSB + 32 +: 3] <= E_IN_TC;
            hdr[32 +: 5] <= E_IN_PORT;
         end
      end
   end

   // Byte to emit this cycle; header octets go most significant first, the MAC sends each LSB first.
   always_comb begin
      emit_valid = 1'b0;
      emit_data = 8'h00;
      case (state)
         mgmt_hdr_pkg::ST_IDLE, mgmt_hdr_pkg::ST_ADDR, mgmt_hdr_pkg::ST_BODY: begin
            emit_valid = take && !(state == mgmt_hdr_pkg::ST_IDLE && next_state inside
               {mgmt_hdr_pkg::ST_DROP, mgmt_hdr_pkg::ST_IDLE});
            emit_data = E_IN_DATA;
         end
         mgmt_hdr_pkg::ST_HDR: begin
            emit_valid = 1'b1;
            emit_data = hdr[63 - 8 * hcnt -: 8];
         end
         default: begin
            emit_valid = 1'b0;
            emit_data = 8'h00;
         end
      endcase
   end

   fcs_engine u_fcs (
      .clk(MCLK),
      .rst(SYS_RST),
      // Also cleared on the last FCS byte, so a frame taken straight after it starts from a clean remainder.
      .init((state == mgmt_hdr_pkg::ST_IDLE && !take) || (state == mgmt_hdr_pkg::ST_FCS && hcnt == 3'h3)),
      .en(emit_valid),
      .data(emit_data),
      .crc(crc)
   );

   // Output stage; the FCS covers every emitted byte, header included.
   always_ff @(posedge MCLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         E_OUT_VALID <= 1'b0;
         E_OUT_DATA <= 8'h00;
         E_OUT_LAST <= 1'b0;
      end else if (state == mgmt_hdr_pkg::ST_FCS) begin
         E_OUT_VALID <= 1'b1;
         E_OUT_DATA <= ~crc[8 * hcnt[1:0] +: 8];
         E_OUT_LAST <= hcnt == 3'h3;
      end else begin
         E_OUT_VALID <= emit_valid;
         E_OUT_DATA <= emit_data;
         E_OUT_LAST <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   // Ingress: strip the four header bytes after the addresses unless the frame is a PAUSE frame.
   // A valid host header never opens with the PAUSE type octet, since opcode 100 is undefined.
   always_ff @(posedge MCLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         icnt <= 6'h0;
         ipause <= 1'b0;
         ihdr <= 32'h0;
         quanta <= 16'h0;
         I_OUT_VALID <= 1'b0;
         I_OUT_DATA <= 8'h00;
         I_OUT_LAST <= 1'b0;
      end else begin
         I_OUT_VALID <= 1'b0;
         I_OUT_LAST <= 1'b0;
         if (I_IN_VALID) begin
            icnt <= I_IN_LAST ? 6'h0 : (icnt == 6'h3F ? icnt : icnt + 6'h1);
            if (icnt == 6'(mgmt_hdr_pkg::MAC_ADDR_BYTES)) begin
               ipause <= I_IN_DATA == mgmt_hdr_pkg::PAUSE_TYPE_HI;
            end
            if (icnt >= 6'(mgmt_hdr_pkg::MAC_ADDR_BYTES) && icnt < 6'(mgmt_hdr_pkg::MAC_ADDR_BYTES + 4)) begin
               ihdr <= {ihdr[23:0], I_IN_DATA};
            end
            if (ipause && icnt[5:1] == 5'(mgmt_hdr_pkg::PAUSE_QUANTA_HI / 2)) begin
               quanta <= {quanta[7:0], I_IN_DATA};
            end
            I_OUT_VALID <= !(icnt >= 6'(mgmt_hdr_pkg::MAC_ADDR_BYTES) && icnt < 6'(mgmt_hdr_pkg::MAC_ADDR_BYTES + 4) &&
               !(icnt == 6'(mgmt_hdr_pkg::MAC_ADDR_BYTES) ? I_IN_DATA == mgmt_hdr_pkg::PAUSE_TYPE_HI : ipause));
            I_OUT_DATA <= I_IN_DATA;
            I_OUT_LAST <= I_IN_LAST;
         end
      end
   end

   // Decoded header, presented for one cycle after its last octet arrives.
   always_ff @(posedge MCLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         I_HDR_VALID <= 1'b0;
         I_LOOKUP <= 1'b0;
         I_TC <= 3'h0;
         I_TAG_POLICY <= 2'h0;
         I_TIME_REQ <= 1'b0;
         I_PORT_MASK <= 23'h0;
         last_ihdr <= 32'h0;
         hdr_count <= 16'h0;
         bad_policy <= 1'b0;
      end else begin
         I_HDR_VALID <= 1'b0;
         if (I_IN_VALID && !ipause && icnt == 6'(mgmt_hdr_pkg::MAC_ADDR_BYTES + 3)) begin
            I_HDR_VALID <= 1'b1;
            I_LOOKUP <= ihdr[23 -: 3] == mgmt_hdr_pkg::OPC_PLAIN;
            I_TC <= ihdr[mgmt_hdr_pkg::IN_TC_LSB - 8 +: 3];
            I_TAG_POLICY <= ihdr[mgmt_hdr_pkg::IN_POL_LSB - 8 +: 2] == mgmt_hdr_pkg::POL_RESERVED ? 2'h0 :
               ihdr[mgmt_hdr_pkg::IN_POL_LSB - 8 +: 2];
            bad_policy <= bad_policy || ihdr[mgmt_hdr_pkg::IN_POL_LSB - 8 +: 2] == mgmt_hdr_pkg::POL_RESERVED;
            I_TIME_REQ <= ihdr[23 -: 3] == mgmt_hdr_pkg::OPC_STAMP && ihdr[mgmt_hdr_pkg::IN_TREQ_BIT - 8];
            I_PORT_MASK <= ihdr[23 -: 3] == mgmt_hdr_pkg::OPC_STAMP ?
               {ihdr[14:0], I_IN_DATA} & mgmt_hdr_pkg::PORT_MASK_VALID : 23'h0;
            last_ihdr <= {ihdr[23:0], I_IN_DATA};
            hdr_count <= hdr_count + 16'h1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   // Pause timer: quanta of 512 bit times at the programmed rate; a new PAUSE frame reloads it.
   always_ff @(posedge MCLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         pause_left <= 16'h0;
         slot_cnt <= 13'h0;
      end else if (I_IN_VALID && I_IN_LAST && ipause) begin
         pause_left <= quanta;
         slot_cnt <= 13'h0;
      end else if (pause_left != 16'h0) begin
         if (slot_cnt == (speed == mgmt_hdr_pkg::SPEED_1000 ? 13'(mgmt_hdr_pkg::SLOT_CYC_1000 - 1) :
               speed == mgmt_hdr_pkg::SPEED_100 ? 13'(mgmt_hdr_pkg::SLOT_CYC_100 - 1) : 13'(SLOT_CYC_10 - 1))) begin
            slot_cnt <= 13'h0;
            pause_left <= pause_left - 16'h1;
         end else begin
            slot_cnt <= slot_cnt + 13'h1;
         end
      end
   end
   assign pause_active = pause_left != 16'h0;

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   // Checks on the design's own behaviour.
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (SYS_RST);

   chk_hdr_after_addr: assert property (
      state == mgmt_hdr_pkg::ST_ADDR && take && !E_IN_LAST && cnt == 4'hB |=> state == mgmt_hdr_pkg::ST_HDR && !E_IN_READY)
      else $error("Header not started after the address bytes.");
   chk_opcode_first: assert property (
      state == mgmt_hdr_pkg::ST_HDR && hcnt == 3'h0 |=> E_OUT_VALID && E_OUT_DATA[7:5] == {2'h0, long_hdr})
      else $error("First header octet does not carry the opcode.");
   chk_drop_silent: assert property (
      state == mgmt_hdr_pkg::ST_DROP |=> !E_OUT_VALID)
      else $error("Dropped frame leaked to the management port.");
   chk_mirror_pass: assert property (
      state == mgmt_hdr_pkg::ST_IDLE && take && !fwd_en && E_IN_CAUSE[0] |=> E_OUT_VALID)
      else $error("Mirrored frame blocked while forwarding is off.");
   chk_pause_bare: assert property (
      state == mgmt_hdr_pkg::ST_IDLE && take && E_IN_PAUSE && !E_IN_LAST |=> state == mgmt_hdr_pkg::ST_BODY)
      else $error("PAUSE frame given a header.");
   chk_dual_select: assert property (
      state == mgmt_hdr_pkg::ST_IDLE && take |=> E_OUT_SEL == $past(dual_en && E_IN_WAN))
      else $error("Wrong management port selected.");
   chk_fcs_length: assert property (
      state == mgmt_hdr_pkg::ST_BODY && take && E_IN_LAST |=>
         (E_OUT_VALID && !E_OUT_LAST) [*4] ##1 (E_OUT_VALID && E_OUT_LAST) ##1 !E_OUT_LAST)
      else $error("FCS is not four bytes ending the frame.");
   chk_mask_ports: assert property (
      I_HDR_VALID |-> (I_PORT_MASK & ~mgmt_hdr_pkg::PORT_MASK_VALID) == 23'h0 && (I_LOOKUP -> I_PORT_MASK == 23'h0))
      else $error("Port mask selects a nonexistent port.");
   chk_pause_holds: assert property (
      state == mgmt_hdr_pkg::ST_IDLE && pause_active && !take |=> !E_IN_READY)
      else $error("New frame accepted during pause.");

   cov_stamp_frame: cover property (state == mgmt_hdr_pkg::ST_HDR && long_hdr && hcnt == 3'h7);
   cov_pause_frame: cover property (I_IN_VALID && I_IN_LAST && ipause);
   cov_drop_frame: cover property (state == mgmt_hdr_pkg::ST_DROP && take && E_IN_LAST);
   cov_host_header: cover property (I_HDR_VALID && I_TIME_REQ);

endmodule : mgmt_port_header_framer

// file: tb/mgmt_host_model.sv
// Host model that sends one framed test frame into the management port.
`timescale 1ns/100ps
module mgmt_host_model (
   // Clock and request.
   input wire logic clk,
   input wire logic go,
   input wire logic [31:0] hdr,
   // Byte stream toward the port.
   output logic valid,
   output logic [7:0] data,
   output logic last
);
   int n = 0;
   // Addresses, header high octet first, then the header's low half again, so a PAUSE frame carries its
   // pause time there; idle data toggles so stale bytes never look valid.
   always @(posedge clk) begin
      if (go || n != 0) begin
         valid <= 1'b1;
         data <= (n >= 12 && n < 16) ? hdr[31 - 8 * (n - 12) -: 8] :
            (n >= 16 && n < 18) ? hdr[15 - 8 * (n - 16) -: 8] : 8'(n);
         last <= n == 19;
         n <= (n == 19) ? 0 : n + 1;
      end else begin
         valid <= 1'b0;
         data <= ~data;
         last <= 1'b0;
      end
   end
endmodule : mgmt_host_model

// file: tb/test_mgmt_port_header_framer.sv
// Self-checking bench for the management port header framer.
`timescale 1ns/100ps
`define CHECK(n, e, g) begin total_checks++; if ((g) !== (e)) begin num_errors++; $display("wrong value %s expected %h seen %h", n, e, g); end end
module test_mgmt_port_header_framer;
   logic MCLK = 1'b0, SYS_RST = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0, go = 1'b0;
   logic [7:0] PADDR = 8'h00, E_IN_DATA = 8'h00, E_IN_CLASS = 8'h00, I_IN_DATA, E_OUT_DATA, I_OUT_DATA;
   logic [31:0] PWDATA = 32'h0, E_IN_TIME = 32'h0, PRDATA, hdr = 32'h0, rd, fcs_seen;
   logic E_IN_VALID = 1'b0, E_IN_LAST = 1'b0, E_IN_PAUSE = 1'b0, E_IN_WAN = 1'b0, E_IN_STAMP = 1'b0, E_IN_DIR = 1'b0;
   logic [5:0] E_IN_CAUSE = 6'h0;
   logic [2:0] E_IN_TC = 3'h0, I_TC;
   logic [4:0] E_IN_PORT = 5'h0;
   logic PREADY, PSLVERR, E_IN_READY, E_OUT_VALID, E_OUT_LAST, E_OUT_SEL, I_IN_VALID, I_IN_LAST, err, sel, elast;
   logic I_OUT_VALID, I_OUT_LAST, I_HDR_VALID, I_LOOKUP, I_TIME_REQ;
   logic [1:0] I_TAG_POLICY, pol;
   logic [22:0] I_PORT_MASK;
   logic [29:0] hseen = 30'h0;
   logic [7:0] q[$];
   int num_errors = 0, total_checks = 0, len, hl, ibytes = 0, ib;
   always #5 MCLK = ~MCLK;
   mgmt_port_header_framer #(.SLOT_CYC_10(8)) dut (.*);
   mgmt_host_model host (.clk(MCLK), .go(go), .hdr(hdr), .valid(I_IN_VALID), .data(I_IN_DATA), .last(I_IN_LAST));
   ////////////////////////////////////////////////////////////////////////////////
   // Collect framed output bytes and decoded host headers.
   always @(posedge MCLK) begin
      if (E_OUT_VALID === 1'b1) begin
         q.push_back(E_OUT_DATA);
         sel <= E_OUT_SEL;
         elast <= E_OUT_LAST;
      end
      if (I_OUT_VALID === 1'b1) ibytes++;
      if (I_HDR_VALID === 1'b1) hseen <= {I_LOOKUP, I_TC, I_TAG_POLICY, I_TIME_REQ, I_PORT_MASK};
   end
   // Expected header toward the CPU, left-aligned in 64 bits.
   function automatic logic [63:0] eg_hdr();
      if (E_IN_STAMP) return {3'h1, 23'h0, E_IN_DIR, E_IN_PORT, E_IN_TIME};
      return {3'h0, 5'h0, E_IN_CLASS, 2'h0, E_IN_CAUSE, E_IN_TC, E_IN_PORT, 32'h0};
   endfunction : eg_hdr
   // Ethernet FCS of the first n collected bytes, complemented; it goes out low byte first.
   function automatic logic [31:0] fcs_of(input int n);
      logic [31:0] c;
      c = 32'hFFFFFFFF;
      for (int i = 0; i < n; i++) begin
         for (int b = 0; b < 8; b++) begin
            c = (c[0] ^ q[i][b]) ? (c >> 1) ^ 32'hEDB88320 : c >> 1;
         end
      end
      return ~c;
   endfunction : fcs_of
   // One APB transfer; ready and data are taken at the edge where ready is seen high.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      PSEL <= 1'b1;
      PWRITE <= wr;
      PADDR <= a;
      PWDATA <= wd;
      @(posedge MCLK);
      PENABLE <= 1'b1;
      do @(posedge MCLK); while (PREADY !== 1'b1);
      rd = PRDATA;
      err = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      // One idle edge, so a following call never drives the strobes twice in one step.
      @(posedge MCLK);
   endtask : apb
   // Send one switch frame with random sideband, then check the framed result.
   task automatic eg_frame(input int kind, input logic [5:0] cause, input int expn);
      logic [63:0] eh;
      E_IN_STAMP <= kind == 1;
      E_IN_PAUSE <= kind == 2;
      E_IN_CLASS <= ($urandom_range(1) != 0) ? 8'($urandom) : 8'h00;
      E_IN_CAUSE <= cause;
      {E_IN_TC, E_IN_PORT, E_IN_DIR} <= 9'($urandom);
      E_IN_TIME <= $urandom;
      len = 12 + $urandom_range(6, 1);
      hl = kind == 1 ? 8 : kind == 2 ? 0 : 4;
      q.delete();
      for (int i = 0; i < len; i++) begin
         E_IN_VALID <= 1'b1;
         E_IN_DATA <= 8'(i);
         E_IN_LAST <= i == len - 1;
         do @(posedge MCLK); while (E_IN_READY !== 1'b1);
      end
      E_IN_VALID <= 1'b0;
      repeat (12) @(posedge MCLK);
      eh = eg_hdr();
      `CHECK("out length", expn < 0 ? len + hl + 4 : expn, q.size())
      for (int i = 0; i < hl && q.size() > 12 + i; i++) begin
         `CHECK("header byte", eh[63 - 8 * i -: 8], q[12 + i])
      end
      for (int i = 0; i + 4 < q.size(); i++) begin
         if (i < 12 || i >= 12 + hl) `CHECK("frame byte", 8'(i < 12 ? i : i - hl), q[i])
      end
      if (q.size() >= 4) begin
         fcs_seen = {q[q.size() - 1], q[q.size() - 2], q[q.size() - 3], q[q.size() - 4]};
         `CHECK("frame check", fcs_of(q.size() - 4), fcs_seen)
         `CHECK("frame end flag", 1'b1, elast)
      end
   endtask : eg_frame
   // Pulse the host model and wait until its 20-byte frame has passed through.
   task automatic host_send();
      go <= 1'b1;
      @(posedge MCLK);
      go <= 1'b0;
      repeat (24) @(posedge MCLK);
   endtask : host_send
   // Closing verdict.
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : tally_and_finish
   ////////////////////////////////////////////////////////////////////////////////
   // Watchdog sized well beyond the full sequence.
   initial begin
      #300000;
      num_errors++;
      tally_and_finish();
   end
   // Main sequence.
   initial begin
      void'($urandom(32'h917A));
      repeat (8) @(posedge MCLK);
      SYS_RST <= 1'b0;
      @(posedge MCLK);
      apb(1'b0, 8'h04, 32'h0);
      `CHECK("status duplex and speed", 4'h9, rd[3:0])
      apb(1'b0, 8'h10, 32'h0);
      `CHECK("unmapped error", 1'b1, err)
      for (int k = 0; k < 9; k++) eg_frame(k % 3, 6'($urandom), -1);
      `CHECK("lan to main port", 1'b0, sel)
      apb(1'b1, 8'h00, 32'h0000000A);
      E_IN_WAN <= 1'b1;
      eg_frame(0, 6'h3E, 0);
      eg_frame(0, 6'h01, -1);
      `CHECK("wan to port five", 1'b1, sel)
      for (int k = 0; k < 6; k++) begin
         hdr = {3'(k % 2), 3'($urandom), 2'(k % 4), 1'($urandom), 23'($urandom) & 23'h13F};
         if (k % 2 == 0) hdr[23:0] = 24'h0;
         pol = hdr[25:24] == 2'h3 ? 2'h0 : hdr[25:24];
         ib = ibytes;
         host_send();
         `CHECK("host header", {k % 2 == 0, hdr[28:26], pol, hdr[23], hdr[22:0]}, hseen)
         `CHECK("host bytes passed", 16, ibytes - ib)
      end
      apb(1'b0, 8'h08, 32'h0);
      `CHECK("last host header", hdr, rd)
      apb(1'b0, 8'h0C, 32'h0);
      `CHECK("header count", 32'h6, rd)
      apb(1'b0, 8'h04, 32'h0);
      `CHECK("reserved policy flag", 1'b1, rd[4])
      // Drop to the 10 Mb/s slot, then let the host send a PAUSE frame of three quanta.
      apb(1'b1, 8'h00, 32'h00000002);
      hdr = 32'h88080003;
      ib = ibytes;
      host_send();
      `CHECK("ready held in pause", 1'b0, E_IN_READY)
      `CHECK("pause frame kept whole", 20, ibytes - ib)
      apb(1'b0, 8'h04, 32'h0);
      `CHECK("status paused at 10", 4'h3, rd[3:0])
      repeat (30) @(posedge MCLK);
      `CHECK("ready after pause", 1'b1, E_IN_READY)
      tally_and_finish();
   end
endmodule : test_mgmt_port_header_framer
